// file: verilog/ana_defs.svh
// Offsets, field positions and reset values of the ability registers.
// Assumes a 32-bit AXI4-Lite bus with byte addresses of at least 8 bits.
`ifndef ANA_DEFS_SVH
`define ANA_DEFS_SVH

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------
`define ANA_IDX_ADV 6'h04
`define ANA_IDX_LP 6'h05
`define ANA_IDX_STRAP 6'h10

// ----------------------------------------------------------------------
// Local advertisement fields
// ----------------------------------------------------------------------
`define ANA_BIT_ASYM 11
`define ANA_BIT_SYM 10
`define ANA_BIT_FD10 6
`define ANA_BIT_HD10 5
// Bits 14 and 9 are reserved and read zero
`define ANA_ADV_WMASK 16'hbdff
// Next page, fault, ext page 0; 100BASE-X both 1; selector 00001
`define ANA_ADV_RST 16'h0181

// ----------------------------------------------------------------------
// Partner base page
// ----------------------------------------------------------------------
`define ANA_LP_RST 16'h0001

// ----------------------------------------------------------------------
// Strap vector positions
// ----------------------------------------------------------------------
`define ANA_STRAP_W 6
`define ANA_STRAP_MAN 0
`define ANA_STRAP_FDFC 1
`define ANA_STRAP_AN 2
`define ANA_STRAP_SPD 3
`define ANA_STRAP_DUP 4
`define ANA_STRAP_FX 5

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define ANA_RDATA_RST 32'h0000_0000

`endif

// file: verilog/ana_pkg.sv
// Types shared by the ability register bank.
// Assumes ana_defs.svh holds the numeric constants.
package ana_pkg;

    // ------------------------------------------------------------------
    // Bus response codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ANA_RESP_OKAY = 2'h0,
        ANA_RESP_SLVERR = 2'h2
    } ana_resp_t;

    // ------------------------------------------------------------------
    // Channel states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ANA_WR_COLLECT = 2'h1,
        ANA_WR_RESP = 2'h2
    } ana_wr_state_t;

    typedef enum logic [1:0] {
        ANA_RD_IDLE = 2'h1,
        ANA_RD_DATA = 2'h2
    } ana_rd_state_t;

endpackage

// file: verilog/ana_regs.sv
// Auto-negotiation ability registers behind an AXI4-Lite slave.
// Assumes straps are static pins and the partner page strobe comes
// from negotiation logic on the same clock.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "ana_defs.svh"

// Summary of operation
// (R1) Bit 5 of advertisement is writable; 1 advertises 10BASE-T half duplex.
// (R2) Bits 4:0 of advertisement are a writable selector, reset 00001.
// (R3) Manual pause strap 0: symmetric pause 1, asymmetric from FD strap.
// (R4) Manual pause strap 1: both pause bits reset to 0.
// (R5) Fiber mode: both pause and both 10BASE-T bits reset to 0.
// (R6) Bit 6 resets to autoneg OR (NOT speed AND duplex).
// (R7) Bit 5 resets to autoneg OR NOT speed.
// (R8) Partner ability register at index 5 is 16-bit read-only.
// (R9) Partner bit 15 shows next-page capability, reset 0.
// (R10) Partner bit 14 shows code word received, reset 0.
// (R11) Partner bit 13 shows remote fault, reset 0.
// (R12) Partner bit 12 shows extended next page, reset 0.
// (R13) Partner bits 11 and 10 show asymmetric and symmetric pause.
// (R14) Partner bit 9 shows 100BASE-T4 ability, reset 0.
// (R15) Partner bits 8 and 7 show 100BASE-X full and half duplex.
// (R16) Partner bits 6 and 5 show 10BASE-T full and half duplex.
// (R17) Partner bits 4:0 hold its selector, reset 00001.
// (R18) Whole partner register loads from one code word at once.
module ana_regs #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic manual_pause_cfg_pin,
    input wire logic full_duplex_pause_cfg_pin,
    input wire logic autoneg_cfg_pin,
    input wire logic speed_cfg_pin,
    input wire logic duplex_cfg_pin,
    input wire logic fiber_mode_pin,
    input wire logic partner_page_valid,
    input wire logic [15:0] partner_page_word,
    output logic [15:0] adv_word
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("ana_regs: ADDR_W must be at least 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [`ANA_STRAP_W-1:0] strap_pins;
    logic [`ANA_STRAP_W-1:0] strap_s1_r;
    logic [`ANA_STRAP_W-1:0] strap_s2_r;
    logic [`ANA_STRAP_W-1:0] strap_cap_r;
    logic load_pending_r;
    logic [15:0] adv_r;
    logic [15:0] adv_dflt;
    logic [15:0] adv_wr_val;
    logic [15:0] lp_r;
    ana_pkg::ana_wr_state_t wr_state_r;
    ana_pkg::ana_wr_state_t wr_state_nxt;
    ana_pkg::ana_rd_state_t rd_state_r;
    ana_pkg::ana_rd_state_t rd_state_nxt;
    logic aw_held_r;
    logic w_held_r;
    logic aw_held_nxt;
    logic w_held_nxt;
    logic [5:0] waddr_r;
    logic [5:0] waddr_use;
    logic [15:0] wdata_r;
    logic [15:0] wdata_use;
    logic [1:0] wstrb_r;
    logic [1:0] wstrb_use;
    logic aw_fire;
    logic w_fire;
    logic b_fire;
    logic ar_fire;
    logic r_fire;
    logic do_write;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    // ------------------------------------------------------------------
    // Strap synchronisers
    // ------------------------------------------------------------------
    // Straps are not reset so that they are settled at reset release.
    assign strap_pins = {fiber_mode_pin, duplex_cfg_pin, speed_cfg_pin,
                         autoneg_cfg_pin, full_duplex_pause_cfg_pin,
                         manual_pause_cfg_pin};

    generate
        for (genvar i = 0; i < `ANA_STRAP_W; i++) begin : g_sync
            always_ff @(posedge aclk) begin
                strap_s1_r[i] <= strap_pins[i];
                strap_s2_r[i] <= strap_s1_r[i];
            end
        end
    endgenerate

    // Capture once, in the first cycle after reset release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_pending_r <= 1'b1;
            strap_cap_r <= '0;
        end else if (load_pending_r) begin
            load_pending_r <= 1'b0;
            strap_cap_r <= strap_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // Advertisement defaults from straps
    // ------------------------------------------------------------------
    always_comb begin
        adv_dflt = `ANA_ADV_RST;
        if (!strap_s2_r[`ANA_STRAP_MAN]) begin
            adv_dflt[`ANA_BIT_SYM] = 1'b1; // see (R3)
            adv_dflt[`ANA_BIT_ASYM] = strap_s2_r[`ANA_STRAP_FDFC]; // see (R3)
        end else begin
            adv_dflt[`ANA_BIT_SYM] = 1'b0; // see (R4)
            adv_dflt[`ANA_BIT_ASYM] = 1'b0; // see (R4)
        end
        adv_dflt[`ANA_BIT_FD10] = strap_s2_r[`ANA_STRAP_AN] |
            (~strap_s2_r[`ANA_STRAP_SPD] &
             strap_s2_r[`ANA_STRAP_DUP]); // see (R6)
        adv_dflt[`ANA_BIT_HD10] = strap_s2_r[`ANA_STRAP_AN] |
            ~strap_s2_r[`ANA_STRAP_SPD]; // see (R7)
        // Fiber overrides every strap
        if (strap_s2_r[`ANA_STRAP_FX]) begin
            adv_dflt[`ANA_BIT_SYM] = 1'b0; // see (R5)
            adv_dflt[`ANA_BIT_ASYM] = 1'b0; // see (R5)
            adv_dflt[`ANA_BIT_FD10] = 1'b0; // see (R5)
            adv_dflt[`ANA_BIT_HD10] = 1'b0; // see (R5)
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign aw_fire = s_axi_awvalid & awready_r;
    assign w_fire = s_axi_wvalid & wready_r;
    assign b_fire = bvalid_r & s_axi_bready;
    assign waddr_use = aw_fire ? s_axi_awaddr[7:2] : waddr_r;
    assign wdata_use = w_fire ? s_axi_wdata[15:0] : wdata_r;
    assign wstrb_use = w_fire ? s_axi_wstrb[1:0] : wstrb_r;

    always_comb begin
        aw_held_nxt = aw_held_r | aw_fire;
        w_held_nxt = w_held_r | w_fire;
        wr_state_nxt = wr_state_r;
        do_write = 1'b0;
        unique case (wr_state_r)
            ana_pkg::ANA_WR_COLLECT: begin
                if (aw_held_nxt && w_held_nxt) begin
                    do_write = 1'b1;
                    wr_state_nxt = ana_pkg::ANA_WR_RESP;
                end
            end
            ana_pkg::ANA_WR_RESP: begin
                if (b_fire) begin
                    aw_held_nxt = 1'b0;
                    w_held_nxt = 1'b0;
                    wr_state_nxt = ana_pkg::ANA_WR_COLLECT;
                end
            end
            default: begin
                aw_held_nxt = 1'b0;
                w_held_nxt = 1'b0;
                wr_state_nxt = ana_pkg::ANA_WR_COLLECT;
            end
        endcase
    end

    // Read-only targets take the write silently; unmapped ones refuse
    always_comb begin
        unique case (waddr_use)
            `ANA_IDX_ADV, `ANA_IDX_LP, `ANA_IDX_STRAP:
                bresp_nxt = ana_pkg::ANA_RESP_OKAY;
            default: bresp_nxt = ana_pkg::ANA_RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_r <= ana_pkg::ANA_WR_COLLECT;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= ana_pkg::ANA_RESP_OKAY;
            waddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else begin
            wr_state_r <= wr_state_nxt;
            aw_held_r <= aw_held_nxt;
            w_held_r <= w_held_nxt;
            awready_r <= (wr_state_nxt == ana_pkg::ANA_WR_COLLECT) &
                         ~aw_held_nxt;
            wready_r <= (wr_state_nxt == ana_pkg::ANA_WR_COLLECT) &
                        ~w_held_nxt;
            if (aw_fire) begin
                waddr_r <= s_axi_awaddr[7:2];
            end
            if (w_fire) begin
                wdata_r <= s_axi_wdata[15:0];
                wstrb_r <= s_axi_wstrb[1:0];
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= bresp_nxt;
            end else if (b_fire) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Local advertisement register
    // ------------------------------------------------------------------
    always_comb begin
        adv_wr_val = adv_r;
        if (wstrb_use[0]) begin
            adv_wr_val[7:0] = wdata_use[7:0]; // see (R1) see (R2)
        end
        if (wstrb_use[1]) begin
            adv_wr_val[15:8] = wdata_use[15:8];
        end
        adv_wr_val = adv_wr_val & `ANA_ADV_WMASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            adv_r <= `ANA_ADV_RST; // see (R2)
        end else if (load_pending_r) begin
            adv_r <= adv_dflt;
        end else if (do_write && waddr_use == `ANA_IDX_ADV) begin
            adv_r <= adv_wr_val; // see (R1)
        end
    end

    // ------------------------------------------------------------------
    // Partner base page
    // ------------------------------------------------------------------
    // One 16-bit load, so a read never sees a torn page
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lp_r <= `ANA_LP_RST; // see (R9) see (R10) see (R17)
        end else if (partner_page_valid) begin
            // Fields map bit for bit onto the received code word
            lp_r <= partner_page_word; // see (R18) see (R11) see (R12)
        end
    end
    // Remaining fields ride along: see (R13) see (R14) see (R15) see (R16)

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    assign ar_fire = s_axi_arvalid & arready_r;
    assign r_fire = rvalid_r & s_axi_rready;

    always_comb begin
        rdata_nxt = `ANA_RDATA_RST;
        rresp_nxt = ana_pkg::ANA_RESP_OKAY;
        unique case (s_axi_araddr[7:2])
            `ANA_IDX_ADV: rdata_nxt[15:0] = adv_r;
            `ANA_IDX_LP: rdata_nxt[15:0] = lp_r; // see (R8)
            `ANA_IDX_STRAP:
                rdata_nxt[`ANA_STRAP_W-1:0] = strap_cap_r;
            default: rresp_nxt = ana_pkg::ANA_RESP_SLVERR;
        endcase
    end

    always_comb begin
        rd_state_nxt = rd_state_r;
        unique case (rd_state_r)
            ana_pkg::ANA_RD_IDLE: begin
                if (ar_fire) begin
                    rd_state_nxt = ana_pkg::ANA_RD_DATA;
                end
            end
            ana_pkg::ANA_RD_DATA: begin
                if (r_fire) begin
                    rd_state_nxt = ana_pkg::ANA_RD_IDLE;
                end
            end
            default: rd_state_nxt = ana_pkg::ANA_RD_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_r <= ana_pkg::ANA_RD_IDLE;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= `ANA_RDATA_RST;
            rresp_r <= ana_pkg::ANA_RESP_OKAY;
        end else begin
            rd_state_r <= rd_state_nxt;
            arready_r <= (rd_state_nxt == ana_pkg::ANA_RD_IDLE);
            rvalid_r <= (rd_state_nxt == ana_pkg::ANA_RD_DATA);
            if (ar_fire) begin
                rdata_r <= rdata_nxt;
                rresp_r <= rresp_nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign adv_word = adv_r;

endmodule

// file: test/ana_regs_monitor.sv
// Checker for the ability register bank, bound to ana_regs.
// Assumes it sees only the ports of ana_regs on one clock.
`timescale 1ns/100ps
module ana_regs_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic manual_pause_cfg_pin,
    input wire logic full_duplex_pause_cfg_pin,
    input wire logic autoneg_cfg_pin,
    input wire logic speed_cfg_pin,
    input wire logic duplex_cfg_pin,
    input wire logic fiber_mode_pin,
    input wire logic [15:0] adv_word
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Reset must be seen while it is held, so no disable here
    property p_adv_rst;
        disable iff (1'b0) !aresetn |=> adv_word == 16'h0181;
    endproperty
    a_adv_rst: assert property (p_adv_rst)
        else $error("advert reset value wrong");

    property p_pause_auto;
        $rose(aresetn) && !fiber_mode_pin && !manual_pause_cfg_pin
        |=> adv_word[10] && adv_word[11] == $past(full_duplex_pause_cfg_pin);
    endproperty
    a_pause_auto: assert property (p_pause_auto)
        else $error("pause default wrong, auto");

    property p_pause_man;
        $rose(aresetn) && !fiber_mode_pin && manual_pause_cfg_pin
        |=> adv_word[11:10] == 2'b00;
    endproperty
    a_pause_man: assert property (p_pause_man)
        else $error("pause default wrong, manual");

    property p_fiber;
        $rose(aresetn) && fiber_mode_pin
        |=> adv_word[11:10] == 2'b00 && adv_word[6:5] == 2'b00;
    endproperty
    a_fiber: assert property (p_fiber)
        else $error("fiber defaults wrong");

    property p_fd10;
        $rose(aresetn) && !fiber_mode_pin |=> adv_word[6] ==
        $past(autoneg_cfg_pin | (!speed_cfg_pin & duplex_cfg_pin));
    endproperty
    a_fd10: assert property (p_fd10)
        else $error("full duplex default wrong");

    property p_hd10;
        $rose(aresetn) && !fiber_mode_pin
        |=> adv_word[5] == $past(autoneg_cfg_pin | !speed_cfg_pin);
    endproperty
    a_hd10: assert property (p_hd10)
        else $error("half duplex default wrong");

    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer late");

    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data dropped");

    property p_rd_upper;
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
    endproperty
    a_rd_upper: assert property (p_rd_upper)
        else $error("upper read bits set");

    property p_err_zero;
        s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0000_0000;
    endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("error read with data");

    property p_wr_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write answer dropped");
endmodule

bind ana_regs ana_regs_monitor u_mon (
    .aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .manual_pause_cfg_pin,
    .full_duplex_pause_cfg_pin, .autoneg_cfg_pin, .speed_cfg_pin,
    .duplex_cfg_pin, .fiber_mode_pin, .adv_word
);

// file: test/ana_lp_model.sv
// Link partner model: hands base pages to the block.
// Assumes send is called just after a rising clock edge.
`timescale 1ns/100ps
module ana_lp_model (
    input wire logic aclk,
    output logic partner_page_valid,
    output logic [15:0] partner_page_word
);
    initial begin
        partner_page_valid = 1'b0;
        partner_page_word = 16'h0000;
    end

    // Word inverted after the strobe, so a late capture shows up
    task send(input logic [15:0] w);
        partner_page_valid <= 1'b1;
        partner_page_word <= w;
        @(posedge aclk);
        partner_page_valid <= 1'b0;
        partner_page_word <= ~w;
    endtask
endmodule

// file: test/tb.sv
// Self-checking bench for the ability register bank.
// Assumes ana_regs, its checker and the partner model are compiled.
`timescale 1ns/100ps
module tb;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, pv;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [5:0] strap;
    logic [15:0] pw, adv;
    int num_errors, cmp_count;
    logic [15:0] pages [11] = '{16'h8001, 16'h4001, 16'h2001, 16'h1001,
        16'h0c01, 16'h0201, 16'h0181, 16'h0061, 16'h001e, 16'hffff, 16'h0000};

    ana_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .manual_pause_cfg_pin(strap[0]),
        .full_duplex_pause_cfg_pin(strap[1]), .autoneg_cfg_pin(strap[2]),
        .speed_cfg_pin(strap[3]), .duplex_cfg_pin(strap[4]),
        .fiber_mode_pin(strap[5]), .partner_page_valid(pv),
        .partner_page_word(pw), .adv_word(adv));
    ana_lp_model u_lp (.aclk(aclk), .partner_page_valid(pv),
        .partner_page_word(pw));

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h want %h", $time, seen, exp);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
            input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the watchdog ends a wait for a missing answer
        while (!done) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                bready <= 1'b0;
                chk(bresp, er);
            end
        end
        // Idle edge, so a next call never rewrites bready at once
        @(posedge aclk);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp,
            input logic [1:0] er);
        logic done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                rready <= 1'b0;
                chk(rdata, exp);
                chk(rresp, er);
            end
        end
        @(posedge aclk);
    endtask

    // Straps must be steady for the whole reset to pass the sync
    task rst(input logic [5:0] s);
        aresetn <= 1'b0;
        strap <= s;
        repeat (8) @(posedge aclk);
        chk(adv, 16'h0181);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    function automatic logic [15:0] exp_adv(input logic [5:0] s);
        logic [15:0] v;
        v = 16'h0181;
        if (!s[5]) begin
            v[10] = !s[0];
            v[11] = !s[0] & s[1];
            v[6] = s[2] | (!s[3] & s[4]);
            v[5] = s[2] | !s[3];
        end
        return v;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_straps();
        for (int s = 0; s < 64; s++) begin
            rst(6'(s));
            rd(8'h10, {16'h0000, exp_adv(6'(s))}, 2'h0);
            chk(adv, exp_adv(6'(s)));
            rd(8'h40, 32'(s), 2'h0);
        end
    endtask

    task t_write();
        wr(8'h10, 32'h0000_ffff, 4'hf, 2'h0);
        rd(8'h10, 32'h0000_bdff, 2'h0);
        wr(8'h10, 32'hffff_0000, 4'h1, 2'h0);
        rd(8'h10, 32'h0000_bd00, 2'h0);
        wr(8'h10, 32'h0000_2021, 4'h1, 2'h0);
        wr(8'h10, 32'h0000_0000, 4'h2, 2'h0);
        chk(adv, 16'h0021);
        wr(8'h14, 32'h0000_1234, 4'hf, 2'h0);
        rd(8'h14, 32'h0000_0001, 2'h0);
        wr(8'h20, 32'h0000_ffff, 4'hf, ana_pkg::ANA_RESP_SLVERR);
        rd(8'h20, 32'h0000_0000, ana_pkg::ANA_RESP_SLVERR);
        chk(adv, 16'h0021);
    endtask

    // Second read shows the page still stands after the strobe
    task t_partner();
        foreach (pages[k]) begin
            u_lp.send(pages[k]);
            rd(8'h14, 32'(pages[k]), 2'h0);
            rd(8'h14, 32'(pages[k]), 2'h0);
        end
        chk(adv, 16'h0021);
        rst(6'h15);
        rd(8'h14, 32'h0000_0001, 2'h0);
    endtask

    task conclude();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        conclude();
    end

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb, strap} = 58'h0;
        num_errors = 0;
        cmp_count = 0;
        @(posedge aclk);
        t_straps();
        t_write();
        t_partner();
        conclude();
    end
endmodule
